/* kbasc_pkg.sv */
package kbasc_pkg;

  // ************************************************************
  // clock and timing
  // ************************************************************
  localparam int CLK_HZ = 125_000_000;
  localparam int CLK_NS = 8;
  localparam int CNT_W = 27;
  localparam int BAUD_LO_HZ = 57_600;
  localparam int BAUD_HI_HZ = 115_200;
  localparam int BAUD_LO_CYC = CLK_HZ / BAUD_LO_HZ;
  localparam int BAUD_HI_CYC = CLK_HZ / BAUD_HI_HZ;
  localparam int BIT_NS = 10_000;
  localparam int EDGE_NS = 3_300;
  localparam int PRE_NS = 50_000;
  localparam int POST_NS = 10_000;
  localparam int LED_NS = 8_000_000;
  localparam int LONG_NS = 1_000_000_000;
  localparam int TYPE_HZ = 10;
  // least times round up
  localparam int BIT_CYC = (BIT_NS + CLK_NS - 1) / CLK_NS;
  localparam int EDGE_CYC = (EDGE_NS + CLK_NS - 1) / CLK_NS;
  localparam int PRE_CYC = (PRE_NS + CLK_NS - 1) / CLK_NS;
  localparam int POST_CYC = (POST_NS + CLK_NS - 1) / CLK_NS;
  localparam int LED_CYC = (LED_NS + CLK_NS - 1) / CLK_NS;
  localparam int LONG_CYC = (LONG_NS + CLK_NS - 1) / CLK_NS;
  localparam int TYPE_CYC = CLK_HZ / TYPE_HZ;

  // ************************************************************
  // keyboard scan codes and output codes
  // ************************************************************
  localparam logic [7:0] SC_BREAK = 8'hF0;
  localparam logic [7:0] SC_EXT = 8'hE0;
  localparam logic [7:0] SC_PAUSE = 8'hE1;
  localparam logic [2:0] PAUSE_SKIP = 3'h7;
  localparam logic [7:0] SC_LSHIFT = 8'h12;
  localparam logic [7:0] SC_RSHIFT = 8'h59;
  localparam logic [7:0] SC_CTRL = 8'h14;
  localparam logic [7:0] SC_ALT = 8'h11;
  localparam logic [7:0] SC_DEL = 8'h71;
  localparam logic [7:0] SC_ESC = 8'h76;
  localparam logic [7:0] SC_CAPS = 8'h58;
  localparam logic [7:0] SC_NUM = 8'h77;
  localparam logic [7:0] SC_SCRL = 8'h7E;
  localparam logic [7:0] SC_ENTER = 8'h5A;
  localparam logic [7:0] SC_SPACE = 8'h29;
  localparam logic [7:0] SC_BKSP = 8'h66;
  localparam logic [7:0] SC_TAB = 8'h0D;
  localparam logic [7:0] SC_KP_PLUS = 8'h79;
  localparam logic [7:0] SC_KP_MINUS = 8'h7B;
  localparam logic [7:0] SC_KP_STAR = 8'h7C;
  localparam logic [7:0] SC_KP_SLASH = 8'h4A;
  localparam logic [7:0] SC_LETTER [26] = '{8'h1C, 8'h32, 8'h21, 8'h23, 8'h24, 8'h2B, 8'h34, 8'h33, 8'h43,
    8'h3B, 8'h42, 8'h4B, 8'h3A, 8'h31, 8'h44, 8'h4D, 8'h15, 8'h2D, 8'h1B, 8'h2C, 8'h3C, 8'h2A, 8'h1D,
    8'h22, 8'h35, 8'h1A};
  localparam logic [7:0] CODE_CAD = 8'hF0;
  localparam logic [7:0] CODE_PAUSE = 8'hE1;
  localparam logic [7:0] CODE_NUM_ON = 8'hE2;
  localparam logic [7:0] CODE_NUM_OFF = 8'hE3;
  localparam logic [7:0] CODE_SCRL_ON = 8'hE4;
  localparam logic [7:0] CODE_SCRL_OFF = 8'hE5;
  localparam logic [7:0] CODE_NONCHAR = 8'h80;
  localparam logic [7:0] CODE_EXTFLIP = 8'h40;

  // ************************************************************
  // carrier
  // ************************************************************
  typedef struct packed {
    logic cad;
    logic esc;
    logic [7:0] code;
  } kbasc_key_t;

endpackage

/* kbasc_top.sv */
`timescale 1ns/1ps

// Contract
// RULE1: baud select low 57.6K, high 115.2K
// RULE2: external reset held low 30us minimum
// RULE3: one byte per make, uart then clocked
// RULE4: clocked bits last about 10us each
// RULE5: clocked port msb first, data inverted
// RULE6: clock edges 3.3us inside each bit
// RULE7: irq low 50us before, 10us after
// RULE8: led pulses low 8ms after irq
// RULE9: ctrl-alt-del: 1s reset, 1s led, F0
// RULE10: escape: 8ms reset aligned with led
// RULE11: reset clears held byte, then waits
// RULE12: no output on key release codes
// RULE13: code ready within microseconds of last bit
// RULE14: shift and caps select letter case
// RULE15: lock keys toggle; num/scroll alternate codes
// RULE16: held over 1s repeats at 10Hz
// RULE17: pause key never repeats
// RULE18: uart frame 8N1, lsb first
// RULE19: keyboard inhibited until outputs complete
// RULE20: host samples while clock low, msb first
// RULE21: keypad operators match main keys
// RULE22: ctrl gui alt app unique codes
// RULE23: clock idles high, eight pulses per byte
module kbasc_top #(
  parameter int unsigned PRE_CYC = kbasc_pkg::PRE_CYC,
  parameter int unsigned LED_CYC = kbasc_pkg::LED_CYC,
  parameter int unsigned LONG_CYC = kbasc_pkg::LONG_CYC,
  parameter int unsigned TYPE_CYC = kbasc_pkg::TYPE_CYC
) (
  // clock and reset
  input wire logic clock,
  input wire logic rst_n,
  input wire logic reset_in_n,
  // keyboard link
  input wire logic kbd_clk_in,
  output logic kbd_clk_out,
  output logic kbd_clk_oe_n,
  input wire logic kbd_data_in,
  // configuration
  input wire logic baud_select,
  // host outputs
  output logic tx,
  output logic shift_clock_out,
  output logic shift_data_out,
  output logic host_irq_n,
  output logic led_flash_n,
  output logic escape_reset_out_n,
  output logic hard_reset_out_n,
  // lock indicators
  output logic caps_lock_on,
  output logic num_lock_on,
  output logic scroll_lock_on
);
  import kbasc_pkg::*;

  typedef enum logic [2:0] {S_IDLE, S_UART, S_PRE, S_SHIFT, S_POST, S_LED} kbasc_state_t;

  // ************************************************************
  // pin synchronisers
  // ************************************************************
  logic [1:0] rin_q, kclk_q, kdat_q, baud_q;
  logic kclk_prev_q;
  logic srst;
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      rin_q <= 2'h3;
      kclk_q <= 2'h3;
      kdat_q <= 2'h3;
      baud_q <= 2'h0;
      kclk_prev_q <= 1'b1;
    end else begin
      rin_q <= {rin_q[0], reset_in_n};
      kclk_q <= {kclk_q[0], kbd_clk_in};
      kdat_q <= {kdat_q[0], kbd_data_in};
      baud_q <= {baud_q[0], baud_select};
      kclk_prev_q <= kclk_q[1];
    end
  end
  // relies on the outside holding the pin low long enough to be seen [RULE2]
  assign srst = !rin_q[1];

  // ************************************************************
  // keyboard frame receiver
  // ************************************************************
  kbasc_state_t st_q;
  logic [10:0] rx_sr_q;
  logic [3:0] rx_cnt_q;
  logic rx_done_q;
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      rx_sr_q <= 11'h000;
      rx_cnt_q <= 4'h0;
      rx_done_q <= 1'b0;
    end else begin
      rx_done_q <= 1'b0;
      if (srst || st_q != S_IDLE) begin
        rx_cnt_q <= 4'h0;
      end else if (kclk_prev_q && !kclk_q[1]) begin
        rx_sr_q <= {kdat_q[1], rx_sr_q[10:1]};
        if (rx_cnt_q == 4'hA) begin
          rx_cnt_q <= 4'h0;
          rx_done_q <= 1'b1; // decoded in the next few cycles [RULE13]
        end else begin
          rx_cnt_q <= rx_cnt_q + 4'h1;
        end
      end
    end
  end

  // ************************************************************
  // scan code decoder
  // ************************************************************
  function automatic logic [7:0] key_code(input logic ext, input logic [7:0] sc, input logic upper);
    logic [7:0] c;
    c = ext ? ((CODE_NONCHAR | sc) ^ CODE_EXTFLIP) : (CODE_NONCHAR | sc); // [RULE22]
    for (int i = 0; i < 26; i++) begin
      if (!ext && sc == SC_LETTER[i]) begin
        c = (upper ? 8'h41 : 8'h61) + 8'(i); // [RULE14]
      end
    end
    if (!ext) begin
      case (sc)
        SC_ESC: c = 8'h1B;
        SC_ENTER: c = 8'h0D;
        SC_SPACE: c = 8'h20;
        SC_BKSP: c = 8'h08;
        SC_TAB: c = 8'h09;
        SC_KP_PLUS: c = 8'h2B; // [RULE21]
        SC_KP_MINUS: c = 8'h2D; // [RULE21]
        SC_KP_STAR: c = 8'h2A; // [RULE21]
        default: ;
      endcase
    end else if (sc == SC_KP_SLASH) begin
      c = 8'h2F; // [RULE21]
    end
    return c;
  endfunction

  logic brk_q, ext_q, shift_l_q, shift_r_q, lctrl_q, lalt_q;
  logic [2:0] skip_q;
  logic [7:0] rx_byte;
  logic [8:0] held_key_q;
  logic held_q;
  kbasc_key_t ev_q, cur_q;
  logic ev_valid_q, ev_take;
  logic [CNT_W-1:0] rep_cnt_q;
  logic rep_first_q;
  assign rx_byte = rx_sr_q[8:1];
  assign ev_take = ev_valid_q && st_q == S_IDLE;

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      brk_q <= 1'b0;
      ext_q <= 1'b0;
      skip_q <= 3'h0;
      shift_l_q <= 1'b0;
      shift_r_q <= 1'b0;
      lctrl_q <= 1'b0;
      lalt_q <= 1'b0;
      caps_lock_on <= 1'b0;
      num_lock_on <= 1'b0;
      scroll_lock_on <= 1'b0;
      held_q <= 1'b0;
      held_key_q <= 9'h000;
      ev_valid_q <= 1'b0;
      ev_q <= '0;
      rep_cnt_q <= '0;
      rep_first_q <= 1'b1;
    end else if (srst) begin
      brk_q <= 1'b0;
      ext_q <= 1'b0;
      skip_q <= 3'h0;
      shift_l_q <= 1'b0;
      shift_r_q <= 1'b0;
      lctrl_q <= 1'b0;
      lalt_q <= 1'b0;
      caps_lock_on <= 1'b0;
      num_lock_on <= 1'b0;
      scroll_lock_on <= 1'b0;
      held_q <= 1'b0;
      ev_valid_q <= 1'b0;
      rep_cnt_q <= '0;
      rep_first_q <= 1'b1;
    end else begin
      if (ev_take) begin
        ev_valid_q <= 1'b0;
      end
      // typematic repeat of the held key [RULE16]
      if (held_q && st_q == S_IDLE && !ev_valid_q) begin
        if (rep_cnt_q == CNT_W'((rep_first_q ? LONG_CYC : TYPE_CYC) - 1)) begin
          rep_cnt_q <= '0;
          rep_first_q <= 1'b0;
          ev_valid_q <= 1'b1;
          ev_q <= '{cad: 1'b0, esc: 1'b0, code: ev_q.code};
        end else begin
          rep_cnt_q <= rep_cnt_q + CNT_W'(1);
        end
      end
      if (rx_done_q) begin
        if (skip_q != 3'h0) begin
          skip_q <= skip_q - 3'h1;
        end else if (rx_byte == SC_BREAK) begin
          brk_q <= 1'b1;
        end else if (rx_byte == SC_EXT) begin
          ext_q <= 1'b1;
        end else if (rx_byte == SC_PAUSE) begin
          // single code, rest of the sequence swallowed, never held [RULE17]
          skip_q <= PAUSE_SKIP;
          held_q <= 1'b0;
          ev_valid_q <= 1'b1;
          ev_q <= '{cad: 1'b0, esc: 1'b0, code: CODE_PAUSE};
        end else begin
          brk_q <= 1'b0;
          ext_q <= 1'b0;
          if (!ext_q && (rx_byte == SC_LSHIFT)) shift_l_q <= !brk_q;
          if (!ext_q && (rx_byte == SC_RSHIFT)) shift_r_q <= !brk_q;
          if (!ext_q && (rx_byte == SC_CTRL)) lctrl_q <= !brk_q;
          if (!ext_q && (rx_byte == SC_ALT)) lalt_q <= !brk_q;
          if (brk_q) begin
            // release codes only drop the held key or clear a shift, ctrl or alt flag [RULE12]
            if (held_key_q == {ext_q, rx_byte}) held_q <= 1'b0;
          end else if (!(held_q && held_key_q == {ext_q, rx_byte})) begin
            held_q <= 1'b1;
            held_key_q <= {ext_q, rx_byte};
            rep_cnt_q <= '0;
            rep_first_q <= 1'b1;
            if (!ext_q && rx_byte == SC_CAPS) begin
              caps_lock_on <= !caps_lock_on; // [RULE15]
              held_q <= 1'b0;
            end else if (!ext_q && rx_byte == SC_NUM) begin
              num_lock_on <= !num_lock_on; // [RULE15]
              ev_valid_q <= 1'b1;
              ev_q <= '{cad: 1'b0, esc: 1'b0, code: num_lock_on ? CODE_NUM_OFF : CODE_NUM_ON};
            end else if (!ext_q && rx_byte == SC_SCRL) begin
              scroll_lock_on <= !scroll_lock_on; // [RULE15]
              ev_valid_q <= 1'b1;
              ev_q <= '{cad: 1'b0, esc: 1'b0, code: scroll_lock_on ? CODE_SCRL_OFF : CODE_SCRL_ON};
            end else if (ext_q && rx_byte == SC_DEL && lctrl_q && lalt_q) begin
              ev_valid_q <= 1'b1;
              ev_q <= '{cad: 1'b1, esc: 1'b0, code: CODE_CAD}; // [RULE9]
            end else begin
              ev_valid_q <= 1'b1; // one byte per make [RULE3]
              ev_q <= '{cad: 1'b0, esc: (!ext_q && rx_byte == SC_ESC),
                        code: key_code(ext_q, rx_byte, (shift_l_q || shift_r_q) ^ caps_lock_on)};
            end
          end
        end
      end
    end
  end

  // ************************************************************
  // output sequencer
  // ************************************************************
  logic [CNT_W-1:0] cnt_q;
  logic [3:0] bit_q;
  logic [9:0] tx_sr_q;
  logic [CNT_W-1:0] baud_len;
  logic [CNT_W-1:0] led_len;
  assign baud_len = baud_q[1] ? CNT_W'(BAUD_HI_CYC - 1) : CNT_W'(BAUD_LO_CYC - 1); // [RULE1]
  assign led_len = cur_q.cad ? CNT_W'(LONG_CYC - 1) : CNT_W'(LED_CYC - 1);

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      st_q <= S_IDLE;
      cnt_q <= '0;
      bit_q <= 4'h0;
      tx_sr_q <= 10'h3FF;
      cur_q <= '0;
    end else if (srst) begin
      st_q <= S_IDLE;
      cnt_q <= '0;
      bit_q <= 4'h0;
      tx_sr_q <= 10'h3FF;
      cur_q <= '0; // held byte cleared [RULE11]
    end else begin
      cnt_q <= cnt_q + CNT_W'(1);
      case (st_q)
        S_IDLE: begin
          cnt_q <= '0;
          if (ev_take) begin
            cur_q <= ev_q;
            tx_sr_q <= {1'b1, ev_q.code, 1'b0}; // stop, data lsb first, start [RULE18]
            bit_q <= 4'h0;
            st_q <= S_UART; // [RULE3]
          end
        end
        S_UART: begin
          if (cnt_q == baud_len) begin
            cnt_q <= '0;
            tx_sr_q <= {1'b1, tx_sr_q[9:1]};
            bit_q <= bit_q + 4'h1;
            if (bit_q == 4'h9) begin
              bit_q <= 4'h0;
              st_q <= S_PRE;
            end
          end
        end
        S_PRE: begin
          if (cnt_q == CNT_W'(PRE_CYC - 1)) begin // [RULE7]
            cnt_q <= '0;
            st_q <= S_SHIFT;
          end
        end
        S_SHIFT: begin
          if (cnt_q == CNT_W'(BIT_CYC - 1)) begin // [RULE4]
            cnt_q <= '0;
            bit_q <= bit_q + 4'h1;
            if (bit_q == 4'h7) begin // [RULE23]
              bit_q <= 4'h0;
              st_q <= S_POST;
            end
          end
        end
        S_POST: begin
          if (cnt_q == CNT_W'(POST_CYC - 1)) begin // [RULE7]
            cnt_q <= '0;
            st_q <= S_LED;
          end
        end
        S_LED: begin
          if (cnt_q == led_len) begin // [RULE8]
            cnt_q <= '0;
            st_q <= S_IDLE;
          end
        end
        default: st_q <= S_IDLE;
      endcase
    end
  end

  // ************************************************************
  // registered pins
  // ************************************************************
  // all pins lag the state by one cycle alike, so relative timing holds
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      tx <= 1'b1;
      shift_clock_out <= 1'b1;
      shift_data_out <= 1'b1;
      host_irq_n <= 1'b1;
      led_flash_n <= 1'b1;
      escape_reset_out_n <= 1'b1;
      hard_reset_out_n <= 1'b1;
      kbd_clk_oe_n <= 1'b1;
    end else begin
      tx <= (st_q == S_UART) ? tx_sr_q[0] : 1'b1; // [RULE18]
      shift_clock_out <= !(st_q == S_SHIFT && cnt_q >= CNT_W'(EDGE_CYC)
                           && cnt_q < CNT_W'(BIT_CYC - EDGE_CYC)); // [RULE6] [RULE23]
      // inverted data, msb first [RULE5]
      shift_data_out <= (st_q == S_SHIFT) ? !cur_q.code[3'(7 - bit_q)] : 1'b1;
      host_irq_n <= !(st_q == S_PRE || st_q == S_SHIFT || st_q == S_POST); // [RULE7]
      led_flash_n <= !(st_q == S_LED); // [RULE8] [RULE9]
      escape_reset_out_n <= !(st_q == S_LED && cur_q.esc); // [RULE10]
      hard_reset_out_n <= !(st_q == S_LED && cur_q.cad); // [RULE9]
      // the clock line is pulled low to hold off the keyboard [RULE19]
      kbd_clk_oe_n <= (st_q == S_IDLE && !ev_valid_q);
    end
  end
  assign kbd_clk_out = 1'b0;

endmodule

/* kbasc_top_properties.sv */
`timescale 1ns/1ps
// ****
// host output timing checks
// ****
module kbasc_top_properties #(
  parameter int unsigned PRE_CYC = kbasc_pkg::PRE_CYC,
  parameter int unsigned LED_CYC = kbasc_pkg::LED_CYC,
  parameter int unsigned LONG_CYC = kbasc_pkg::LONG_CYC
) (
  // clock and reset
  input wire logic clock,
  input wire logic rst_n,
  // host side
  input wire logic tx,
  input wire logic shift_clock_out,
  input wire logic shift_data_out,
  input wire logic host_irq_n,
  input wire logic led_flash_n,
  input wire logic escape_reset_out_n,
  input wire logic hard_reset_out_n,
  // keyboard link
  input wire logic kbd_clk_oe_n
);
  logic sck_q;
  logic fall_w;
  logic [3:0] pulses_q;
  logic [31:0] low_q, gap_q, rise_q, irq_q, led_q;

  assign fall_w = sck_q & ~shift_clock_out;

  // counters wrap only after about 34 s of idle, far beyond any run
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      sck_q <= 1'b1;
      pulses_q <= 4'h0;
      low_q <= 32'h0;
      gap_q <= 32'h0;
      rise_q <= 32'h0;
      irq_q <= 32'h0;
      led_q <= 32'h0;
    end else begin
      sck_q <= shift_clock_out;
      pulses_q <= host_irq_n ? 4'h0 : pulses_q + {3'h0, fall_w};
      low_q <= shift_clock_out ? 32'h0 : low_q + 32'h1;
      gap_q <= fall_w ? 32'h1 : gap_q + 32'h1;
      rise_q <= (shift_clock_out & ~sck_q) ? 32'h1 : rise_q + 32'h1;
      irq_q <= host_irq_n ? 32'h0 : irq_q + 32'h1;
      led_q <= led_flash_n ? 32'h0 : led_q + 32'h1;
    end
  end

  default clocking cb @(posedge clock); endclocking
  default disable iff (!rst_n);

  sequence s_irq_end;
    $rose(host_irq_n);
  endsequence
  sequence s_first_fall;
    fall_w && pulses_q == 4'h0 && !host_irq_n;
  endsequence

  a_clk_idle: assert property (host_irq_n |-> shift_clock_out && shift_data_out)
    else $error("shift port active outside a byte");
  a_byte_pulses: assert property (s_irq_end |-> pulses_q == 4'h8)
    else $error("clock pulse count per byte wrong");
  a_bit_period: assert property (fall_w && pulses_q != 4'h0 |-> gap_q inside {[1249:1251]})
    else $error("clocked bit period wrong");
  a_clk_inset: assert property ($rose(shift_clock_out) && !host_irq_n |-> low_q inside {[423:425]})
    else $error("clock low pulse not inset");
  a_irq_lead: assert property (s_first_fall |-> irq_q inside {[PRE_CYC + 409 : PRE_CYC + 417]})
    else $error("irq lead time wrong");
  a_irq_trail: assert property (s_irq_end |-> rise_q inside {[1659:1667]})
    else $error("irq trail time wrong");
  a_led_follow: assert property (s_irq_end |-> ##[0:1] !led_flash_n)
    else $error("led pulse does not follow irq");
  a_led_width: assert property ($rose(led_flash_n) |-> led_q inside
    {[LED_CYC - 1 : LED_CYC + 1], [LONG_CYC - 1 : LONG_CYC + 1]})
    else $error("led pulse length wrong");
  a_esc_align: assert property ($changed(escape_reset_out_n) |-> $changed(led_flash_n))
    else $error("escape reset not aligned with led");
  a_hard_align: assert property (!hard_reset_out_n |-> !led_flash_n)
    else $error("hard reset outside led pulse");
  a_kbd_inhibit: assert property (!host_irq_n || !led_flash_n || !tx |-> !kbd_clk_oe_n)
    else $error("keyboard released while outputs busy");
  a_uart_first: assert property ($fell(host_irq_n) |-> tx && $stable(tx))
    else $error("irq started before serial frame ended");
endmodule

bind kbasc_top kbasc_top_properties #(.PRE_CYC(PRE_CYC), .LED_CYC(LED_CYC), .LONG_CYC(LONG_CYC)) u_props (
  .clock(clock), .rst_n(rst_n), .tx(tx), .shift_clock_out(shift_clock_out), .shift_data_out(shift_data_out),
  .host_irq_n(host_irq_n), .led_flash_n(led_flash_n), .escape_reset_out_n(escape_reset_out_n),
  .hard_reset_out_n(hard_reset_out_n), .kbd_clk_oe_n(kbd_clk_oe_n));

/* kbasc_host_model.sv */
`timescale 1ns/1ps
// ****
// host receiving both output ports
// ****
module kbasc_host_model (
  // clock and reset
  input wire logic clock,
  input wire logic rst_n,
  // device outputs and baud select
  input wire logic baud_select,
  input wire logic tx,
  input wire logic shift_clock_out,
  input wire logic shift_data_out,
  input wire logic host_irq_n,
  // captured results
  output logic [7:0] uart_byte,
  output logic [7:0] shift_byte,
  output int uart_n,
  output int shift_n,
  output int pulses,
  output int bad_bits
);
  import kbasc_pkg::*;
  int len;
  logic lo_bit;
  logic [7:0] sr;

  initial begin
    uart_byte = 8'h00;
    shift_byte = 8'h00;
    sr = 8'h00;
  end

  // mid-bit sampling: a wrong bit rate corrupts the byte
  always begin
    @(negedge tx);
    if (rst_n) begin
      len = baud_select ? BAUD_HI_CYC : BAUD_LO_CYC;
      repeat (len / 2) @(posedge clock);
      for (int i = 0; i < 8; i++) begin
        repeat (len) @(posedge clock);
        uart_byte[i] = tx;
      end
      repeat (len) @(posedge clock);
      if (tx === 1'b1) uart_n++;
    end
  end

  always @(negedge host_irq_n) pulses = 0;
  always @(negedge shift_clock_out) lo_bit = shift_data_out;
  // data read while clock low must match the rising edge read
  always @(posedge shift_clock_out) begin
    if (!host_irq_n) begin
      if (shift_data_out !== lo_bit) bad_bits++;
      sr = {sr[6:0], ~shift_data_out};
      pulses++;
    end
  end
  always @(posedge host_irq_n) begin
    if (rst_n) begin
      shift_byte = sr;
      shift_n++;
    end
  end
endmodule

/* tb_kbasc_top.sv */
`timescale 1ns/1ps
module tb_kbasc_top;
  import kbasc_pkg::*;
  logic clock, rst_n, reset_in_n, kbd_clk_in, kbd_data_in, baud_select;
  logic kbd_clk_out, kbd_clk_oe_n, tx, shift_clock_out, shift_data_out, host_irq_n, led_flash_n;
  logic escape_reset_out_n, hard_reset_out_n, caps_lock_on, num_lock_on, scroll_lock_on;
  logic [7:0] uart_byte, shift_byte;
  logic [7:0] exp_q[$];
  int uart_n, shift_n, pulses, bad_bits, n_mismatch, checks, led_len, esc_len, hard_len, idx;

  kbasc_top #(.PRE_CYC(20), .LED_CYC(50), .LONG_CYC(2000), .TYPE_CYC(1000)) DUT (
    .clock(clock), .rst_n(rst_n), .reset_in_n(reset_in_n), .kbd_clk_in(kbd_clk_in), .kbd_clk_out(kbd_clk_out),
    .kbd_clk_oe_n(kbd_clk_oe_n), .kbd_data_in(kbd_data_in), .baud_select(baud_select), .tx(tx),
    .shift_clock_out(shift_clock_out), .shift_data_out(shift_data_out), .host_irq_n(host_irq_n),
    .led_flash_n(led_flash_n), .escape_reset_out_n(escape_reset_out_n), .hard_reset_out_n(hard_reset_out_n),
    .caps_lock_on(caps_lock_on), .num_lock_on(num_lock_on), .scroll_lock_on(scroll_lock_on));

  kbasc_host_model u_host (
    .clock(clock), .rst_n(rst_n), .baud_select(baud_select), .tx(tx), .shift_clock_out(shift_clock_out),
    .shift_data_out(shift_data_out), .host_irq_n(host_irq_n), .uart_byte(uart_byte), .shift_byte(shift_byte),
    .uart_n(uart_n), .shift_n(shift_n), .pulses(pulses), .bad_bits(bad_bits));

  initial begin
    clock = 1'b0;
    forever #4 clock = ~clock;
  end

  // pulse lengths of the latest sequence
  always @(posedge clock) begin
    if (!host_irq_n) begin
      led_len <= 0;
      esc_len <= 0;
      hard_len <= 0;
    end else begin
      if (!led_flash_n) led_len <= led_len + 1;
      if (!escape_reset_out_n) esc_len <= esc_len + 1;
      if (!hard_reset_out_n) hard_len <= hard_len + 1;
    end
  end

  task automatic chk(logic [31:0] seen, logic [31:0] exp);
    checks++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  task automatic test_done();
    $display("mismatches %0d checks %0d", n_mismatch, checks);
    if (n_mismatch == 0 && checks > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask

  task automatic cyc(int n);
    repeat (n) @(posedge clock);
  endtask

  // keyboard frame at 80 ns per bit, clock still between frames
  task automatic kbd_byte(logic [7:0] b);
    logic [10:0] f;
    int k;
    f = {1'b1, ~^b, b, 1'b0};
    for (k = 0; k < 4000 && kbd_clk_oe_n !== 1'b1; k++) @(posedge clock);
    if (kbd_clk_oe_n !== 1'b1) begin
      n_mismatch++;
      test_done();
    end
    for (int i = 0; i < 11; i++) begin
      kbd_data_in <= f[i];
      cyc(5);
      kbd_clk_in <= 1'b0;
      cyc(5);
      kbd_clk_in <= 1'b1;
    end
    cyc(5);
    kbd_data_in <= 1'b1;
    cyc(20);
  endtask

  task automatic expect_out(logic [7:0] code);
    int n0, k;
    n0 = shift_n;
    exp_q.push_back(code);
    for (k = 0; k < 40000 && shift_n == n0; k++) @(posedge clock);
    if (shift_n == n0) begin
      n_mismatch++;
      test_done();
    end
    cyc(120);
    chk(uart_byte, exp_q[0]);
    chk(shift_byte, exp_q.pop_front());
    chk(pulses, 8);
    chk(uart_n, shift_n);
    chk(bad_bits, 0);
    chk(led_len, 50);
    chk(hard_len, 0);
  endtask

  task automatic release_key(logic [7:0] sc);
    kbd_byte(SC_BREAK);
    kbd_byte(sc);
    cyc(300);
    chk({tx, host_irq_n}, 2'h3);
  endtask

  initial begin
    rst_n = 1'b0;
    reset_in_n = 1'b1;
    kbd_clk_in = 1'b1;
    kbd_data_in = 1'b1;
    baud_select = 1'b0;
    idx = $urandom(32'h7984);
    idx = $urandom_range(25, 0);
    cyc(20);
    rst_n <= 1'b1;
    cyc(5);
    chk({tx, host_irq_n, led_flash_n, kbd_clk_oe_n}, 4'hF);
    kbd_byte(SC_LETTER[idx]);
    // start bit already out and keyboard held off a few cycles after the last edge
    chk({tx, kbd_clk_oe_n, kbd_clk_out}, 3'h0);
    expect_out(8'h61 + idx[7:0]);
    chk(esc_len, 0);
    release_key(SC_LETTER[idx]);
    baud_select <= 1'b1;
    cyc(5);
    kbd_byte(SC_ESC);
    expect_out(8'h1B);
    chk(esc_len, 50);
    release_key(SC_ESC);
    // caps lock alone gives no byte
    kbd_byte(SC_CAPS);
    cyc(300);
    chk({caps_lock_on, num_lock_on, scroll_lock_on, tx, host_irq_n}, 5'h13);
    release_key(SC_CAPS);
    // extended release alone gives no byte
    kbd_byte(SC_EXT);
    release_key(SC_DEL);
    // held letter: upper case, then one typematic repeat
    kbd_byte(SC_LETTER[1]);
    expect_out(8'h42);
    expect_out(8'h42);
    release_key(SC_LETTER[1]);
    reset_in_n <= 1'b0;
    cyc(3750);
    reset_in_n <= 1'b1;
    cyc(10);
    chk({caps_lock_on, host_irq_n, shift_data_out, shift_clock_out}, 4'h7);
    test_done();
  end
endmodule
